//--- pkg/epo_pkg.sv
// shared constants and types of the energy pulse output block
package epo_pkg;
	// register byte offsets
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_MASK   = 8'h08;
	localparam logic [7:0] ADDR_LIVE   = 8'h0c;
	localparam logic [7:0] ADDR_CALCNT = 8'h10;
	localparam logic [7:0] ADDR_CALTH  = 8'h14;
	// field positions
	localparam int CTRL_EN_BIT   = 0;
	localparam int ST_CAL_BIT    = 0;
	localparam int ST_LF_BIT     = 1;
	localparam int ST_FLAG_BIT   = 2;
	localparam int LIVE_FLAG_BIT = 0;
	localparam int LIVE_SEL_LSB  = 1;
	// reset values
	localparam logic [31:0] CTRL_RST  = 32'h0000_0001;
	localparam logic [2:0]  MASK_RST  = 3'h0;
	localparam logic [31:0] CALTH_RST = 32'h0010_0000;
	// axi response codes
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// datapath widths
	localparam int SMP_W = 16;
	localparam int PWR_W = 40;
	localparam int ACC_W = 48;
	localparam int HPF_SHIFT = 10;
	// timing
	localparam int CLK_MHZ     = 10;
	localparam int CF_WIDTH_NS = 10000;
	localparam int LF_WIDTH_NS = 1000000;
	localparam int CF_WIDTH_CYC = (CF_WIDTH_NS * CLK_MHZ + 999) / 1000;
	localparam int LF_WIDTH_CYC = (LF_WIDTH_NS * CLK_MHZ + 999) / 1000;
	// low-frequency thresholds per rate code, gain shifts per gain code
	localparam logic [31:0] LF_TH0 = 32'h8000_0000;
	localparam logic [31:0] LF_TH1 = 32'h4000_0000;
	localparam logic [31:0] LF_TH2 = 32'h2000_0000;
	localparam logic [31:0] LF_TH3 = 32'h1000_0000;
	localparam logic [4:0] GAIN_SH0 = 5'h0;
	localparam logic [4:0] GAIN_SH1 = 5'h1;
	localparam logic [4:0] GAIN_SH2 = 5'h3;
	localparam logic [4:0] GAIN_SH3 = 5'h4;
	// static select pins
	typedef struct packed {
		logic calRateSelect;
		logic rateSelectHi;
		logic rateSelectLo;
		logic gainSelectHi;
		logic gainSelectLo;
		logic highpassSelect;
	} epo_sel_t;
	localparam int SEL_W = $bits(epo_sel_t);
endpackage

//--- hw/epo_sync.sv
// two-flop synchroniser for a bundle of level inputs
`timescale 1ns/1ps
module epo_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,     // block clock
	input  wire logic         reset_n, // sync reset, low active
	input  wire logic [W-1:0] async,   // levels from pins
	output logic      [W-1:0] synced   // levels on clk
);
	logic [W-1:0] stage1_r;

	// one pair of flops per bit; stage1 feeds only stage2
	genvar g;
	generate
		for (g = 0; g < W; g++)
		begin : gBit
			always_ff @(posedge clk)
			begin
				if (!reset_n)
				begin
					stage1_r[g] <= 1'b0;
					synced[g]   <= 1'b0;
				end
				else
				begin
					stage1_r[g] <= async[g];
					synced[g]   <= stage1_r[g];
				end
			end
		end
	endgenerate
endmodule

//--- hw/epo_pulse_gen.sv
// accumulate signed power and emit stretched pulses at a threshold
`timescale 1ns/1ps
module epo_pulse_gen
	import epo_pkg::*;
(
	input  wire logic                    clk,       // block clock
	input  wire logic                    reset_n,   // sync reset, low
	input  wire logic                    enable,    // run accumulator
	input  wire logic signed [PWR_W-1:0] power,     // power sample
	input  wire logic                    powerVld,  // sample strobe
	input  wire logic        [31:0]      threshold, // energy per pulse
	input  wire logic        [15:0]      widthCyc,  // pulse width
	output logic                         pulse,     // stretched level
	output logic                         fire,      // one-cycle event
	output logic                         negative   // sign of last fire
);
	logic signed [ACC_W-1:0] acc_r;
	logic signed [ACC_W-1:0] sum;
	logic signed [ACC_W-1:0] thS;
	logic        [15:0]      width_r;
	logic                    firePos;
	logic                    fireNeg;

	// next sum and threshold crossing either way
	always_comb
	begin
		sum = acc_r + ACC_W'(power);
		thS = ACC_W'({16'h0000, threshold});
		firePos = enable && powerVld && (sum >= thS);
		fireNeg = enable && powerVld && (sum <= -thS);
	end

	// accumulator keeps remainder so no energy is lost
	always_ff @(posedge clk)
	begin
		if (!reset_n || !enable)
			acc_r <= '0;
		else if (firePos)
			acc_r <= sum - thS;
		else if (fireNeg)
			acc_r <= sum + thS;
		else if (powerVld)
			acc_r <= sum;
	end

	// event and sign registered together
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			fire     <= 1'b0;
			negative <= 1'b0;
		end
		else
		begin
			fire <= firePos || fireNeg;
			if (firePos || fireNeg)
				negative <= fireNeg;
		end
	end

	// width counter restarts on each event
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			width_r <= '0;
			pulse   <= 1'b0;
		end
		else if (fire)
		begin
			width_r <= widthCyc;
			pulse   <= 1'b1;
		end
		else if (width_r > 16'h0001)
			width_r <= width_r - 16'h0001;
		else
		begin
			width_r <= '0;
			pulse   <= 1'b0;
		end
	end
endmodule

//--- hw/epo_top.sv
// energy pulse output control with axi4-lite registers
//
// Decided for this implementation: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
module epo_top
	import epo_pkg::*;
#(
	parameter int LF_WIDTH = LF_WIDTH_CYC
) (
	input  wire logic                    clk,           // block clock
	input  wire logic                    reset_n,       // sync, low
	input  wire logic signed [SMP_W-1:0] currentSample, // current adc
	input  wire logic signed [SMP_W-1:0] voltageSample, // voltage adc
	input  wire logic                    sampleValid,   // sample strobe
	input  wire epo_sel_t                selPins,       // static pins
	output logic                         calibrationPulseOut, // cal
	output logic                         energyPulseA,  // low freq a
	output logic                         energyPulseB,  // low freq b
	output logic                         negativePowerFlag, // sign
	output logic                         irq,           // interrupt
	input  wire logic [7:0]              s_axi_awaddr,  // write addr
	input  wire logic                    s_axi_awvalid, // aw valid
	output logic                         s_axi_awready, // aw ready
	input  wire logic [31:0]             s_axi_wdata,   // write data
	input  wire logic [3:0]              s_axi_wstrb,   // byte enables
	input  wire logic                    s_axi_wvalid,  // w valid
	output logic                         s_axi_wready,  // w ready
	output logic [1:0]                   s_axi_bresp,   // write resp
	output logic                         s_axi_bvalid,  // b valid
	input  wire logic                    s_axi_bready,  // b ready
	input  wire logic [7:0]              s_axi_araddr,  // read addr
	input  wire logic                    s_axi_arvalid, // ar valid
	output logic                         s_axi_arready, // ar ready
	output logic [31:0]                  s_axi_rdata,   // read data
	output logic [1:0]                   s_axi_rresp,   // read resp
	output logic                         s_axi_rvalid,  // r valid
	input  wire logic                    s_axi_rready   // r ready
);
	localparam logic [15:0] CF_W = 16'(CF_WIDTH_CYC);
	localparam logic [15:0] LF_W = 16'(LF_WIDTH);

	epo_sel_t                sel;
	logic signed [SMP_W-1:0] dc_r;
	logic signed [SMP_W:0]   curFilt;
	logic signed [PWR_W-1:0] curGain;
	logic signed [PWR_W-1:0] power_r;
	logic                    powerVld_r;
	logic        [31:0]      ctrl_r;
	logic        [31:0]      calTh_r;
	logic        [31:0]      calThEff;
	logic        [31:0]      lfTh;
	logic        [2:0]       status_r;
	logic        [2:0]       mask_r;
	logic        [31:0]      calCnt_r;
	logic                    calPulse;
	logic                    calFire;
	logic                    calNeg;
	logic                    calFireD_r;
	logic                    lfPulse;
	logic                    lfFire;
	logic                    sideB_r;
	logic                    enable;
	logic        [7:0]       awAddr_r;
	logic                    awHeld_r;
	logic        [31:0]      wData_r;
	logic        [3:0]       wStrb_r;
	logic                    wHeld_r;
	logic                    doWrite;
	logic                    doRead;
	logic        [2:0]       evt;
	logic        [2:0]       rdClr;

	// decode of the two-bit gain code into a left shift
	function automatic logic [4:0] gain_shift(input logic [1:0] code);
		unique case (code)
			2'h0: gain_shift = GAIN_SH0;
			2'h1: gain_shift = GAIN_SH1;
			2'h2: gain_shift = GAIN_SH2;
			2'h3: gain_shift = GAIN_SH3;
		endcase
	endfunction

	// decode of the two-bit rate code into a pulse threshold
	function automatic logic [31:0] rate_th(input logic [1:0] code);
		unique case (code)
			2'h0: rate_th = LF_TH0;
			2'h1: rate_th = LF_TH1;
			2'h2: rate_th = LF_TH2;
			2'h3: rate_th = LF_TH3;
		endcase
	endfunction

	// static pins come from outside the clock domain
	epo_sync #(
		.W(SEL_W)
	) uSync (
		.clk     (clk),
		.reset_n (reset_n),
		.async   (selPins),
		.synced  (sel)
	);

	assign enable = ctrl_r[CTRL_EN_BIT];

	// dc tracker: slow leaky average of the current channel
	always_ff @(posedge clk)
	begin
		if (!reset_n)
			dc_r <= '0;
		else if (sampleValid && sel.highpassSelect)
			dc_r <= dc_r + SMP_W'((currentSample - dc_r) >>> HPF_SHIFT);
	end

	// filter applied or bypassed, then gain stage
	always_comb
	begin
		if (sel.highpassSelect)
			curFilt = (SMP_W+1)'(currentSample) - (SMP_W+1)'(dc_r);
		else
			curFilt = (SMP_W+1)'(currentSample);
		curGain = PWR_W'(curFilt) <<< gain_shift({sel.gainSelectHi,
			sel.gainSelectLo});
	end

	// instantaneous power product, registered
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			power_r    <= '0;
			powerVld_r <= 1'b0;
		end
		else
		begin
			power_r    <= PWR_W'(curGain * PWR_W'(voltageSample));
			powerVld_r <= sampleValid;
		end
	end

	// thresholds from the select pins
	always_comb
	begin
		calThEff = sel.calRateSelect ? {1'b0, calTh_r[31:1]} : calTh_r;
		lfTh     = rate_th({sel.rateSelectHi, sel.rateSelectLo});
	end

	// calibration channel: short integration of power
	epo_pulse_gen uCal (
		.clk       (clk),
		.reset_n   (reset_n),
		.enable    (enable),
		.power     (power_r),
		.powerVld  (powerVld_r),
		.threshold (calThEff),
		.widthCyc  (CF_W),
		.pulse     (calPulse),
		.fire      (calFire),
		.negative  (calNeg)
	);

	// low-frequency channel: long integration, average power
	epo_pulse_gen uLf (
		.clk       (clk),
		.reset_n   (reset_n),
		.enable    (enable),
		.power     (power_r),
		.powerVld  (powerVld_r),
		.threshold (lfTh),
		.widthCyc  (LF_W),
		.pulse     (lfPulse),
		.fire      (lfFire),
		.negative  ()
	);

	// registered pulse outputs; side flips as the pulse starts, so a leads
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			sideB_r             <= 1'b0;
			calibrationPulseOut <= 1'b0;
			energyPulseA        <= 1'b0;
			energyPulseB        <= 1'b0;
		end
		else
		begin
			if (lfFire)
				sideB_r <= !sideB_r;
			calibrationPulseOut <= calPulse;
			energyPulseA        <= lfPulse && sideB_r;
			energyPulseB        <= lfPulse && !sideB_r;
		end
	end

	// sign moves at the edge that raises the calibration pin, held until the next one
	always_ff @(posedge clk)
	begin
		calFireD_r <= reset_n && calFire;
		if (!reset_n)
			negativePowerFlag <= 1'b0;
		else if (calFireD_r)
			negativePowerFlag <= calNeg;
	end

	// calibration pulse counter
	always_ff @(posedge clk)
	begin
		if (!reset_n)
			calCnt_r <= '0;
		else if (calFire)
			calCnt_r <= calCnt_r + 32'h0000_0001;
	end

	// sticky events: set beats the read clear
	assign evt = {calFire && (calNeg != negativePowerFlag), lfFire, calFire};
	assign rdClr = (doRead && s_axi_araddr == ADDR_STATUS) ? 3'h7 : 3'h0;

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			status_r <= '0;
		else
			status_r <= (status_r & ~rdClr) | evt;
	end

	assign irq = |(status_r & mask_r);

	// write channel capture, address and data in either order
	assign s_axi_awready = !awHeld_r && !s_axi_bvalid;
	assign s_axi_wready  = !wHeld_r && !s_axi_bvalid;
	assign doWrite       = awHeld_r && wHeld_r;

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			awHeld_r <= 1'b0;
			wHeld_r  <= 1'b0;
			awAddr_r <= '0;
			wData_r  <= '0;
			wStrb_r  <= '0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				awHeld_r <= 1'b1;
				awAddr_r <= s_axi_awaddr;
			end
			else if (doWrite)
				awHeld_r <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
			begin
				wHeld_r <= 1'b1;
				wData_r <= s_axi_wdata;
				wStrb_r <= s_axi_wstrb;
			end
			else if (doWrite)
				wHeld_r <= 1'b0;
		end
	end

	// register writes with byte enables
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			ctrl_r  <= CTRL_RST;
			mask_r  <= MASK_RST;
			calTh_r <= CALTH_RST;
		end
		else if (doWrite)
		begin
			for (int b = 0; b < 4; b++)
			begin
				if (wStrb_r[b] && awAddr_r == ADDR_CTRL)
					ctrl_r[b*8 +: 8] <= wData_r[b*8 +: 8];
				if (wStrb_r[b] && awAddr_r == ADDR_CALTH)
					calTh_r[b*8 +: 8] <= wData_r[b*8 +: 8];
			end
			if (wStrb_r[0] && awAddr_r == ADDR_MASK)
				mask_r <= wData_r[2:0];
		end
	end

	// write response
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end
		else if (doWrite)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (awAddr_r == ADDR_CTRL || awAddr_r == ADDR_MASK ||
				awAddr_r == ADDR_CALTH) ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// read channel: one cycle to data
	assign s_axi_arready = !s_axi_rvalid;
	assign doRead        = s_axi_arvalid && s_axi_arready;

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= RESP_OKAY;
		end
		else if (doRead)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= RESP_OKAY;
			unique case (s_axi_araddr)
				ADDR_CTRL:   s_axi_rdata <= ctrl_r;
				ADDR_STATUS: s_axi_rdata <= {29'h0, status_r};
				ADDR_MASK:   s_axi_rdata <= {29'h0, mask_r};
				ADDR_LIVE:   s_axi_rdata <= {25'h0, sel, negativePowerFlag};
				ADDR_CALCNT: s_axi_rdata <= calCnt_r;
				ADDR_CALTH:  s_axi_rdata <= calTh_r;
				default:
				begin
					s_axi_rdata <= '0;
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end
endmodule

//--- tb/epo_top_chk.sv
// pulse and bus timing checker for epo_top
`timescale 1ns/1ps
module epo_top_chk
	import epo_pkg::*;
#(
	parameter int LF_WIDTH = 20
) (
	input wire logic	clk,	// clock
	input wire logic	reset_n,	// reset
	input wire logic	calibrationPulseOut,	// cal pulse
	input wire logic	energyPulseA,	// phase a
	input wire logic	energyPulseB,	// phase b
	input wire logic	negativePowerFlag,	// sign
	input wire logic	s_axi_awvalid,	// aw valid
	input wire logic	s_axi_awready,	// aw ready
	input wire logic	s_axi_wvalid,	// w valid
	input wire logic	s_axi_wready,	// w ready
	input wire logic	s_axi_bvalid,	// b valid
	input wire logic	s_axi_arvalid,	// ar valid
	input wire logic	s_axi_arready,	// ar ready
	input wire logic	s_axi_rvalid,	// r valid
	input wire logic [1:0]	s_axi_rresp,	// r resp
	input wire logic [31:0]	s_axi_rdata	// r data
);
	logic [15:0]	cfLen_r;
	logic [15:0]	lfLen_r;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	// length of the pulse now high on each output
	always_ff @(posedge clk)
	begin
		cfLen_r <= (reset_n && calibrationPulseOut) ? cfLen_r + 1'b1 : '0;
		lfLen_r <= (reset_n && (energyPulseA || energyPulseB)) ?
			lfLen_r + 1'b1 : '0;
	end
	property p_cfWidth;
		$fell(calibrationPulseOut) |-> cfLen_r == CF_WIDTH_CYC;
	endproperty
	a_cfWidth: assert property (p_cfWidth)
		else $error("calibration pulse width wrong");
	property p_lfWidth;
		$fell(energyPulseA || energyPulseB) |-> lfLen_r == LF_WIDTH;
	endproperty
	a_lfWidth: assert property (p_lfWidth)
		else $error("energy pulse width wrong");
	property p_lfApart;
		!(energyPulseA && energyPulseB);
	endproperty
	a_lfApart: assert property (p_lfApart)
		else $error("both energy phases high");
	property p_flagAtCf;
		$changed(negativePowerFlag) |-> $rose(calibrationPulseOut);
	endproperty
	a_flagAtCf: assert property (p_flagAtCf)
		else $error("flag moved without a calibration pulse");
	property p_rdLat;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rdLat: assert property (p_rdLat)
		else $error("read answer late");
	property p_wrLat;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			|-> ##2 s_axi_bvalid;
	endproperty
	a_wrLat: assert property (p_wrLat)
		else $error("write answer late");
	property p_noAr;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_noAr: assert property (p_noAr)
		else $error("read taken while answer pending");
	property p_errZero;
		s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == '0;
	endproperty
	a_errZero: assert property (p_errZero)
		else $error("error read returned data");
endmodule
bind epo_top epo_top_chk #(.LF_WIDTH(LF_WIDTH)) u_chk (.*);

//--- tb/epo_meter_model.sv
// meter side: stepper counter and calibration input
`timescale 1ns/1ps
module epo_meter_model (
	input wire logic	clk,	// clock
	input wire logic	reset_n,	// reset
	input wire logic	clear,	// zero tallies
	input wire logic	energyPulseA,	// phase a
	input wire logic	energyPulseB,	// phase b
	input wire logic	calibrationPulseOut,	// cal pulse
	output logic [15:0]	lfCount,	// steps
	output logic [15:0]	calCount,	// cal pulses
	output logic	orderErr	// phase out of turn
);
	logic	prevA, prevB, prevC, nextA, riseA, riseB;
	assign riseA = energyPulseA & ~prevA;
	assign riseB = energyPulseB & ~prevB;
	// previous levels for edge detection
	always_ff @(posedge clk)
	begin
		prevA <= energyPulseA;
		prevB <= energyPulseB;
		prevC <= calibrationPulseOut;
	end
	// tallies of steps and calibration pulses
	always_ff @(posedge clk)
	begin
		if (!reset_n || clear)
		begin
			lfCount <= 16'h0;
			calCount <= 16'h0;
		end
		else
		begin
			lfCount <= lfCount + 16'(riseA | riseB);
			calCount <= calCount + 16'(calibrationPulseOut & ~prevC);
		end
	end
	// a stepper needs its phases in turn, a first
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			orderErr <= 1'b0;
			nextA <= 1'b1;
		end
		else if (riseA || riseB)
		begin
			orderErr <= orderErr | (riseA != nextA) | (riseA & riseB);
			nextA <= riseB;
		end
	end
endmodule

//--- tb/energy_pulse_output_control_tb.sv
// self-checking bench for the energy pulse output block
`timescale 1ns/1ps
module energy_pulse_output_control_tb;
	import epo_pkg::*;
	typedef struct {
		logic [5:0]	sel;
		logic [15:0]	smp;
		logic [15:0]	cal;
		logic [15:0]	lf;
	} epo_row_t;
	logic	clk, reset_n, sampleValid, clear, irq, orderErr;
	logic signed [SMP_W-1:0]	currentSample, voltageSample;
	epo_sel_t	selPins;
	logic	calibrationPulseOut, energyPulseA, energyPulseB;
	logic	negativePowerFlag, s_axi_bready, s_axi_rready;
	logic	s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic	s_axi_bvalid, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic [7:0]	s_axi_awaddr, s_axi_araddr;
	logic [31:0]	s_axi_wdata, s_axi_rdata;
	logic [3:0]	s_axi_wstrb;
	logic [1:0]	s_axi_bresp, s_axi_rresp;
	logic [15:0]	lfCount, calCount;
	int	fails, cmp_count;
	// select pins, sample value, cal and step counts over 32 samples
	epo_row_t rows [7] = '{
		'{6'h20, 16'h0100, 16'h4, 16'h0},
		'{6'h00, 16'h0100, 16'h2, 16'h0},
		'{6'h02, 16'h0100, 16'h4, 16'h0},
		'{6'h04, 16'h0100, 16'h10, 16'h0},
		'{6'h06, 16'h0100, 16'h20, 16'h0},
		'{6'h18, 16'h4000, 16'hffff, 16'h20},
		'{6'h00, 16'h4000, 16'hffff, 16'h4}
	};
	epo_top #(.LF_WIDTH(20)) uut (.*);
	epo_meter_model partner (.*);
	// compare, optionally allowing one less for threshold rounding
	task automatic chk(input logic [31:0] g, e, input bit s = 0);
		cmp_count++;
		if (g !== e && !(s && g === e - 1))
		begin
			fails++;
			$display("mismatch at %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic close_out();
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// one write, held until taken, response checked
	task automatic axw(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp, r);
	endtask
	// one read, data and response checked
	task automatic axr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata, d);
		chk(s_axi_rresp, r);
	endtask
	// samples spaced wider than a calibration pulse
	task automatic feed(input logic [15:0] c, v, input int n);
		repeat (n)
		begin
			currentSample <= c;
			voltageSample <= v;
			sampleValid <= 1'b1;
			@(posedge clk);
			sampleValid <= 1'b0;
			repeat (109) @(posedge clk);
		end
	endtask
	// 10 MHz block clock
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// watchdog over the whole run
	initial
	begin
		repeat (60000) @(posedge clk);
		fails++;
		close_out();
	end
	// main sequence
	initial
	begin
		{reset_n, sampleValid, clear, currentSample, voltageSample} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hf;
		selPins = 6'h21;
		repeat (4) @(posedge clk);
		chk({calibrationPulseOut, energyPulseA, energyPulseB,
			negativePowerFlag, irq}, 32'h0);
		reset_n <= 1'b1;
		axr(ADDR_CTRL, CTRL_RST, RESP_OKAY);
		axr(ADDR_MASK, 32'h0, RESP_OKAY);
		axr(ADDR_CALTH, CALTH_RST, RESP_OKAY);
		axr(ADDR_CALCNT, 32'h0, RESP_OKAY);
		axr(ADDR_LIVE, 32'h42, RESP_OKAY);
		axr(8'h18, 32'h0, RESP_SLVERR);
		axw(ADDR_STATUS, 32'h7, RESP_SLVERR);
		foreach (rows[i])
		begin
			selPins <= rows[i].sel;
			clear <= 1'b1;
			repeat (3) @(posedge clk);
			clear <= 1'b0;
			feed(rows[i].smp, rows[i].smp, 32);
			if (rows[i].cal != 16'hffff)
				chk(calCount, rows[i].cal, 1);
			chk(lfCount, rows[i].lf, 1);
		end
		chk(orderErr, 32'h0);
		chk(irq, 32'h0);
		axw(ADDR_MASK, 32'h7, RESP_OKAY);
		chk(irq, 32'h1);
		axr(ADDR_STATUS, 32'h3, RESP_OKAY);
		@(posedge clk);
		chk(irq, 32'h0);
		axw(ADDR_CTRL, 32'h0, RESP_OKAY);
		axw(ADDR_CTRL, 32'h1, RESP_OKAY);
		feed(16'hc000, 16'h4000, 1);
		chk(negativePowerFlag, 32'h1);
		chk(irq, 32'h1);
		axr(ADDR_STATUS, 32'h5, RESP_OKAY);
		feed(16'h4000, 16'h4000, 2);
		chk(negativePowerFlag, 32'h0);
		axr(ADDR_STATUS, 32'h5, RESP_OKAY);
		reset_n <= 1'b0;
		repeat (2) @(posedge clk);
		chk(irq, 32'h0);
		reset_n <= 1'b1;
		axr(ADDR_MASK, 32'h0, RESP_OKAY);
		// filter on: offset tracking keeps four samples just under threshold
		selPins <= 6'h01;
		clear <= 1'b1;
		repeat (3) @(posedge clk);
		clear <= 1'b0;
		feed(16'h4000, 16'h0010, 4);
		chk(calCount, 32'h0);
		// filter bypassed: the same four samples reach threshold exactly
		selPins <= 6'h00;
		axw(ADDR_CTRL, 32'h0, RESP_OKAY);
		axw(ADDR_CTRL, 32'h1, RESP_OKAY);
		feed(16'h4000, 16'h0010, 4);
		chk(calCount, 32'h1);
		// single byte lane write to the threshold
		s_axi_wstrb <= 4'h2;
		axw(ADDR_CALTH, 32'h1234_5678, RESP_OKAY);
		axr(ADDR_CALTH, 32'h0010_5600, RESP_OKAY);
		close_out();
	end
endmodule
